// ===== verilog/pmx_pkg.sv
package pmx_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_TYPE = 12'h000;
  localparam logic [11:0] OFS_STATE = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;
  localparam logic [11:0] OFS_CAP_ONE = 12'h00C;
  localparam logic [11:0] OFS_CAP_ONE_CTL = 12'h010;
  localparam logic [11:0] OFS_LANE_CAP = 12'h014;
  localparam logic [11:0] OFS_PARTNER_LANE = 12'h018;
  localparam logic [11:0] OFS_LOW_POWER = 12'h01C;
  localparam logic [11:0] OFS_UP_LOW_POWER = 12'h020;
  localparam logic [11:0] OFS_EXT_STATUS = 12'h024;
  localparam logic [11:0] OFS_EXT_CONTROL = 12'h028;
  localparam logic [11:0] OFS_EXT_CAP = 12'h02C;
  localparam logic [11:0] OFS_PARTNER_EXT_CAP = 12'h030;
  localparam logic [11:0] OFS_TX_EQ = 12'h034;

  // Fixed values
  localparam logic [3:0] LAYER_TYPE_CODE = 4'h1;
  localparam logic [1:0] ARC_MAX = 2'h1;
  localparam int CTL_ARC_LSB = 0;

  typedef enum logic [3:0] {
    PMX_ST_DOWN = 4'h0,
    PMX_ST_UP = 4'h1,
    PMX_ST_RETRAIN = 4'h2,
    PMX_ST_LP1 = 4'h7,
    PMX_ST_LP2 = 4'h8,
    PMX_ST_UP_LP1 = 4'hB
  } pmx_state_t;

  typedef enum logic [1:0] {
    PMX_TR_NONE = 2'h0,
    PMX_TR_OK = 2'h1,
    PMX_TR_FAIL = 2'h2
  } pmx_train_t;

  typedef enum logic [2:0] {
    PMX_CODE_6466 = 3'h0,
    PMX_CODE_NONE = 3'h1,
    PMX_CODE_128130 = 3'h2
  } pmx_code_t;

  typedef enum logic [2:0] {
    PMX_RATE_25G78 = 3'h0,
    PMX_RATE_20G = 3'h1,
    PMX_RATE_28G125 = 3'h2
  } pmx_rate_t;

  // Extended field positions
  localparam int EXT_EN_BIT = 0;
  localparam int EXT_TR_LSB = 1;
  localparam int EXT_CODE_LSB = 3;
  localparam int EXT_RATE_LSB = 6;
  localparam int CTL_CODE_LSB = 0;
  localparam int CTL_RATE_LSB = 3;
  localparam int CTL_RSVD_LSB = 6;
  localparam logic [31:0] EXT_CAP_VALUE = 32'h0000001B;
  localparam logic [31:0] PARTNER_CAP_MASK = 32'h0000001B;
  localparam logic [31:0] TX_EQ_RESET = 32'h00000000;

  // Training-side status inputs
  typedef struct packed {
    pmx_state_t state;
    logic ext_enabled;
    pmx_train_t train;
    pmx_code_t code;
    pmx_rate_t rate;
  } pmx_status_t;

  // Controls toward the training logic
  typedef struct packed {
    logic [1:0] retrain_arc;
    logic phit_crc_en;
    pmx_code_t code;
    pmx_rate_t rate;
    logic [31:0] tx_eq;
  } pmx_control_t;

endpackage : pmx_pkg

// ===== verilog/pmx_regs.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module pmx_regs (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Training logic side
  input wire pmx_pkg::pmx_status_t i_status,
  output pmx_pkg::pmx_control_t o_control
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic code_ok(input logic [2:0] v);
    code_ok = (v == pmx_pkg::PMX_CODE_6466) || (v == pmx_pkg::PMX_CODE_NONE)
      || (v == pmx_pkg::PMX_CODE_128130);
  endfunction : code_ok

  function automatic logic rate_ok(input logic [2:0] v);
    rate_ok = (v == pmx_pkg::PMX_RATE_25G78) || (v == pmx_pkg::PMX_RATE_20G)
      || (v == pmx_pkg::PMX_RATE_28G125);
  endfunction : rate_ok

  function automatic logic state_ok(input logic [3:0] v);
    state_ok = (v == pmx_pkg::PMX_ST_DOWN) || (v == pmx_pkg::PMX_ST_UP)
      || (v == pmx_pkg::PMX_ST_RETRAIN) || (v == pmx_pkg::PMX_ST_LP1)
      || (v == pmx_pkg::PMX_ST_LP2) || (v == pmx_pkg::PMX_ST_UP_LP1);
  endfunction : state_ok

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] cur_reg;
  logic [3:0] cur_next;
  logic [3:0] prev_reg;
  logic [3:0] prev_next;
  logic [1:0] arc_reg;
  logic [1:0] arc_next;
  logic crc_en_reg;
  logic crc_en_next;
  logic [2:0] code_reg;
  logic [2:0] code_next;
  logic [2:0] rate_reg;
  logic [2:0] rate_next;
  logic [25:0] ctl_rsvd_reg;
  logic [25:0] ctl_rsvd_next;
  logic [31:0] partner_reg;
  logic [31:0] partner_next;
  logic [31:0] tx_eq_reg;
  logic [31:0] tx_eq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] rd_word;
  logic [31:0] ext_status;

  // Write in the access phase, read captured in the setup phase, zero wait states
  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && !i_penable && !i_pwrite;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    ext_status = '0;
    ext_status[pmx_pkg::EXT_EN_BIT] = i_status.ext_enabled;
    ext_status[pmx_pkg::EXT_TR_LSB +: 2] = i_status.train;
    ext_status[pmx_pkg::EXT_CODE_LSB +: 3] = i_status.code;
    ext_status[pmx_pkg::EXT_RATE_LSB +: 3] = i_status.rate;
  end

  // Decode for both read data and error
  always_comb
  begin
    hit = 1'b1;
    rd_word = '0;
    case (i_paddr)
      pmx_pkg::OFS_TYPE: rd_word[3:0] = pmx_pkg::LAYER_TYPE_CODE;
      pmx_pkg::OFS_STATE: rd_word[7:0] = {prev_reg, cur_reg};
      pmx_pkg::OFS_CONTROL: rd_word[pmx_pkg::CTL_ARC_LSB +: 2] = arc_reg;
      pmx_pkg::OFS_CAP_ONE: rd_word = '0;
      pmx_pkg::OFS_CAP_ONE_CTL: rd_word[0] = crc_en_reg;
      pmx_pkg::OFS_LANE_CAP: rd_word = '0;
      pmx_pkg::OFS_PARTNER_LANE: rd_word = '0;
      pmx_pkg::OFS_LOW_POWER: rd_word = '0;
      pmx_pkg::OFS_UP_LOW_POWER: rd_word = '0;
      pmx_pkg::OFS_EXT_STATUS: rd_word = ext_status;
      pmx_pkg::OFS_EXT_CONTROL: rd_word = {ctl_rsvd_reg, rate_reg, code_reg};
      pmx_pkg::OFS_EXT_CAP: rd_word = pmx_pkg::EXT_CAP_VALUE;
      pmx_pkg::OFS_PARTNER_EXT_CAP: rd_word = partner_reg;
      pmx_pkg::OFS_TX_EQ: rd_word = tx_eq_reg;
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cur_next = cur_reg;
    prev_next = prev_reg;
    arc_next = arc_reg;
    crc_en_next = crc_en_reg;
    code_next = code_reg;
    rate_next = rate_reg;
    ctl_rsvd_next = ctl_rsvd_reg;
    partner_next = partner_reg;
    tx_eq_next = tx_eq_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    // Reserved state codes are dropped, not reported
    if (state_ok(i_status.state) && (i_status.state != cur_reg))
    begin
      cur_next = i_status.state;
      prev_next = cur_reg;
    end
    if (rd)
    begin
      rdata_next = rd_word;
      err_next = !hit;
    end
    else if (i_psel && !i_penable)
    begin
      err_next = !hit;
    end
    if (wr && hit)
    begin
      case (i_paddr)
        pmx_pkg::OFS_CONTROL:
        begin
          if (i_pwdata[pmx_pkg::CTL_ARC_LSB +: 2] <= pmx_pkg::ARC_MAX)
            arc_next = i_pwdata[pmx_pkg::CTL_ARC_LSB +: 2];
        end
        pmx_pkg::OFS_CAP_ONE_CTL: crc_en_next = i_pwdata[0];
        pmx_pkg::OFS_EXT_CONTROL:
        begin
          if (code_ok(i_pwdata[pmx_pkg::CTL_CODE_LSB +: 3]))
            code_next = i_pwdata[pmx_pkg::CTL_CODE_LSB +: 3];
          if (rate_ok(i_pwdata[pmx_pkg::CTL_RATE_LSB +: 3]))
            rate_next = i_pwdata[pmx_pkg::CTL_RATE_LSB +: 3];
          ctl_rsvd_next = i_pwdata[31:pmx_pkg::CTL_RSVD_LSB];
        end
        pmx_pkg::OFS_PARTNER_EXT_CAP:
          partner_next = i_pwdata & pmx_pkg::PARTNER_CAP_MASK;
        pmx_pkg::OFS_TX_EQ: tx_eq_next = i_pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cur_reg <= pmx_pkg::PMX_ST_DOWN;
      prev_reg <= pmx_pkg::PMX_ST_DOWN;
      arc_reg <= '0;
      crc_en_reg <= 1'b0;
      code_reg <= pmx_pkg::PMX_CODE_6466;
      rate_reg <= pmx_pkg::PMX_RATE_25G78;
      ctl_rsvd_reg <= '0;
      partner_reg <= '0;
      tx_eq_reg <= pmx_pkg::TX_EQ_RESET;
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end
    else
    begin
      cur_reg <= cur_next;
      prev_reg <= prev_next;
      arc_reg <= arc_next;
      crc_en_reg <= crc_en_next;
      code_reg <= code_next;
      rate_reg <= rate_next;
      ctl_rsvd_reg <= ctl_rsvd_next;
      partner_reg <= partner_next;
      tx_eq_reg <= tx_eq_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_prdata = rdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = err_reg && i_psel && i_penable;
  assign o_control = '{retrain_arc: arc_reg, phit_crc_en: crc_en_reg,
    code: pmx_pkg::pmx_code_t'(code_reg), rate: pmx_pkg::pmx_rate_t'(rate_reg),
    tx_eq: tx_eq_reg};

endmodule : pmx_regs

// ===== test/pmx_regs_asserts.sv
`timescale 1ns/1ns
module pmx_regs_asserts (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire pmx_pkg::pmx_status_t i_status,
  input wire pmx_pkg::pmx_control_t o_control
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Read data is captured at setup, so check it in the access cycle
  wire logic rd = i_psel && !i_penable && !i_pwrite;
  wire logic wr = i_psel && i_penable && i_pwrite && i_paddr == pmx_pkg::OFS_EXT_CONTROL;
  ////////////////////////////////////////////////////////////////////////////////
  type_read_a: assert property (rd && i_paddr == 12'h000 |=> o_prdata == 32'h1)
    else $error("type code wrong");
  zero_reads_a: assert property (rd && i_paddr inside {12'h00C, [12'h014:12'h020]}
    |=> o_prdata == 32'h0) else $error("excluded field not zero");
  ctl_reset_a: assert property ($rose(i_rst_n) |-> o_control.code == 3'h0
    && o_control.rate == 3'h0 && !o_control.phit_crc_en) else $error("reset value wrong");
  arc_legal_a: assert property (o_control.retrain_arc <= 2'h1)
    else $error("arc out of range");
  ext_status_a: assert property (rd && i_paddr == 12'h024 |=> o_prdata ==
    {23'h0, $past(i_status.rate), $past(i_status.code), $past(i_status.train),
    $past(i_status.ext_enabled)}) else $error("ext status wrong");
  code_write_a: assert property (wr && i_pwdata[2:0] <= 3'h2 |=>
    o_control.code == $past(i_pwdata[2:0])) else $error("coding not taken");
  code_keep_a: assert property (wr && i_pwdata[2:0] > 3'h2 |=> $stable(o_control.code))
    else $error("bad coding taken");
  rate_legal_a: assert property (o_control.rate <= 3'h2)
    else $error("rate reserved");
  cap_read_a: assert property (rd && i_paddr == 12'h02C |=> o_prdata == 32'h1B)
    else $error("capability wrong");
  cover property (wr);
  cover property (rd && i_paddr == 12'h024);
  cover property (o_pslverr);
endmodule : pmx_regs_asserts

// ===== test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, err;
  pmx_pkg::pmx_status_t i_status = '0;
  pmx_pkg::pmx_control_t o_control;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  pmx_regs pmx_regs_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_status(i_status), .o_control(o_control));
  initial forever #2 i_mclk = ~i_mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Whole run is about 80 cycles
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rchk
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rchk("type", pmx_pkg::OFS_TYPE, 32'h1);
    rchk("crc", pmx_pkg::OFS_CAP_ONE_CTL, 32'h0);
    rchk("ectl", pmx_pkg::OFS_EXT_CONTROL, 32'h0);
    rchk("ecap", pmx_pkg::OFS_EXT_CAP, 32'h1B);
    rchk("estat", pmx_pkg::OFS_EXT_STATUS, 32'h0);
    for (int k = 3; k < 9; k++) if (k != 4) rchk("zero", 12'(k * 4), 32'h0);
    i_status <= '{pmx_pkg::PMX_ST_UP, 1'b1, pmx_pkg::PMX_TR_OK, pmx_pkg::PMX_CODE_128130,
      pmx_pkg::PMX_RATE_28G125};
    repeat (3) @(posedge i_mclk);
    i_status.state <= pmx_pkg::PMX_ST_LP2;
    repeat (3) @(posedge i_mclk);
    // Reserved state must not disturb the history
    i_status.state <= pmx_pkg::pmx_state_t'(4'h3);
    apb(1'b0, pmx_pkg::OFS_STATE, 32'h0);
    chk("state", 32'h18, rd & 32'hFF);
    rchk("estat", pmx_pkg::OFS_EXT_STATUS, 32'h93);
    apb(1'b1, pmx_pkg::OFS_EXT_CONTROL, 32'hFFFFFFD1);
    rchk("ectl", pmx_pkg::OFS_EXT_CONTROL, 32'hFFFFFFD1);
    apb(1'b1, pmx_pkg::OFS_EXT_CONTROL, 32'h3F);
    rchk("ectl", pmx_pkg::OFS_EXT_CONTROL, 32'h11);
    apb(1'b1, pmx_pkg::OFS_CONTROL, 32'h1);
    apb(1'b1, pmx_pkg::OFS_CONTROL, 32'h3);
    rchk("arc", pmx_pkg::OFS_CONTROL, 32'h1);
    chk("arcout", {30'h0, o_control.retrain_arc}, 32'h1);
    chk("ready", {31'h0, o_pready}, 32'h1);
    apb(1'b1, pmx_pkg::OFS_CAP_ONE_CTL, 32'h1);
    apb(1'b1, pmx_pkg::OFS_PARTNER_EXT_CAP, 32'hFFFFFFFF);
    rchk("pcap", pmx_pkg::OFS_PARTNER_EXT_CAP, 32'h1B);
    apb(1'b1, pmx_pkg::OFS_TX_EQ, 32'hA5A55A5A);
    rchk("unmap", 12'h100, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("txeq", o_control.tx_eq, 32'hA5A55A5A);
    chk("crcen", {31'h0, o_control.phit_crc_en}, 32'h1);
    chk("code", {29'h0, o_control.code}, 32'h1);
    chk("rate", {29'h0, o_control.rate}, 32'h2);
    end_sim();
  end
endmodule : tb_top
bind pmx_regs pmx_regs_asserts pmx_regs_asserts_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_status(i_status), .o_control(o_control));
